// >>> design/rx_np_ram.v
`timescale 1ns/1ps
`include "rx_tlp_stream_defs.vh"

// ==========================================================
// parked non-posted beats, registered read with write bypass
module rx_np_ram #(
  parameter AW = 4,
  parameter W = `RXS_BUF_W
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [W-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [W-1:0] o_rdata
);

  reg [W-1:0] mem [0:(1<<AW)-1];

  always @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // bypass so a beat written into the head slot is not read stale
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= {W{1'b0}};
    end else if (i_we && (i_waddr == i_raddr)) begin
      o_rdata <= i_wdata;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule

// >>> design/rx_tlp_stream.v
`timescale 1ns/1ps
`include "rx_tlp_stream_defs.vh"

// Functional notes
// - first beat: valid and start low, first full 128-bit word on data
// - later beats: start high, valid low, advance on sink-ready cycles
// - valid goes high when no beat is available next cycle
// - single-beat packet: start and end together, remainder 00 or 01
// - remainder at end: 00 four dwords, 01 upper three, 10 upper two, 11 top one
// - straddle: packet ends upper qword, next starts lower, remainder bit 1 set
// - a packet starts in lower qword only on a straddle, start and end both low
// - beat offered while sink not ready is held unchanged until taken
// - mid-packet stall of any length freezes the stream
// - new packet may start the cycle after previous end
// - posted and completion packets overtake blocked non-posted packets
// - held non-posted packets go out first once np-accept returns
module rx_tlp_stream #(
  parameter NP_AW = 4
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_in_valid,
  output reg o_in_ready,
  input wire [127:0] i_in_data,
  input wire i_in_sof,
  input wire i_in_eof,
  input wire [1:0] i_in_rem,
  input wire i_in_np,
  output reg [127:0] o_rx_data,
  output reg o_rx_sof_n,
  output reg o_rx_eof_n,
  output reg [1:0] o_rx_rem_n,
  output reg o_rx_src_rdy_n,
  input wire i_rx_dst_rdy_n,
  input wire i_rx_np_ok_n
);

  localparam [NP_AW:0] BUF_DEPTH = {1'b1, {NP_AW{1'b0}}};
  localparam [NP_AW:0] CNT_ZERO = {(NP_AW+1){1'b0}};
  localparam [NP_AW:0] CNT_ONE = {{NP_AW{1'b0}}, 1'b1};

  // ==========================================================
  // input skid, two entries so the ready output can be a flop
  wire [`RXS_SKID_W-1:0] in_word = {i_in_np, i_in_sof, i_in_eof, i_in_rem, i_in_data};
  reg [`RXS_SKID_W-1:0] skid0_reg;
  reg [`RXS_SKID_W-1:0] skid1_reg;
  reg [1:0] skid_cnt_reg;
  reg [1:0] skid_cnt_next;
  wire h_valid = (skid_cnt_reg != 2'd0);
  wire h_np = skid0_reg[`RXS_POS_NP];
  wire h_sof = skid0_reg[`RXS_POS_SOF];
  wire h_eof = skid0_reg[`RXS_POS_EOF];
  wire push = i_in_valid & o_in_ready;
  wire pop;

  // ==========================================================
  // packet steering and non-posted parking
  reg busy_reg;
  reg sel_buf_reg;
  reg div_reg;
  reg [NP_AW:0] buf_cnt_reg;
  reg [NP_AW:0] np_pkts_reg;
  reg [NP_AW-1:0] wr_ptr_reg;
  reg [NP_AW-1:0] rd_ptr_reg;
  wire [`RXS_BUF_W-1:0] buf_rdata;
  reg s_take;

  wire np_any = (np_pkts_reg != CNT_ZERO);
  // np-accept is looked at only when a packet starts, one late np may still pass
  wire np_blocked = i_rx_np_ok_n | np_any | (busy_reg & sel_buf_reg);
  wire in_div = h_sof ? (h_np & np_blocked) : div_reg;
  wire buf_full = (buf_cnt_reg == BUF_DEPTH);
  // a non-posted packet longer than the buffer stalls the input for good
  wire buf_wr = h_valid & in_div & ~buf_full;
  wire pick_buf = ~busy_reg & ~i_rx_np_ok_n & np_any;
  wire use_buf = busy_reg ? sel_buf_reg : pick_buf;
  wire use_in = h_valid & ~in_div & (busy_reg ? ~sel_buf_reg : (~pick_buf & h_sof));
  wire [`RXS_BUF_W-1:0] s_word = use_buf ? buf_rdata : skid0_reg[`RXS_BUF_W-1:0];
  wire s_valid = use_buf | use_in;
  wire [127:0] s_data = s_word[`RXS_DATA_W-1:0];
  wire s_sof = s_word[`RXS_POS_SOF];
  wire s_eof = s_word[`RXS_POS_EOF];
  wire [1:0] s_rem = s_word[`RXS_POS_REM+1:`RXS_POS_REM];
  wire buf_rd = s_take & use_buf;
  wire in_take = s_take & use_in;
  wire [NP_AW-1:0] buf_raddr = rd_ptr_reg + {{(NP_AW-1){1'b0}}, buf_rd};
  assign pop = in_take | buf_wr;

  rx_np_ram #(
    .AW(NP_AW),
    .W(`RXS_BUF_W)
  ) rx_np_ram_inst (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_we(buf_wr),
    .i_waddr(wr_ptr_reg),
    .i_wdata(skid0_reg[`RXS_BUF_W-1:0]),
    .i_raddr(buf_raddr),
    .o_rdata(buf_rdata)
  );

  // ==========================================================
  // realigner: packets ending in the upper qword let the next start low
  reg [63:0] carry_reg;
  reg shift_reg;
  reg pend_reg;
  reg pend_rem0_reg;
  reg pend_sof_reg;
  reg [63:0] carry_next;
  reg shift_next;
  reg pend_next;
  reg pend_rem0_next;
  reg pend_sof_next;
  reg [127:0] data_next;
  reg sof_next;
  reg eof_next;
  reg [1:0] rem_next;
  reg srdy_next;
  // a held beat moves only on a cycle where the sink is ready
  wire adv = o_rx_src_rdy_n | ~i_rx_dst_rdy_n;
  // a lone short packet cannot sit low beside an ending one: two ends in one beat
  // lower-half starts only ride on a straddle, a lone lower start is never made
  wire straddle = s_valid & s_sof & ~pend_sof_reg & ~(s_eof & s_rem[1]);

  always @* begin
    s_take = 1'b0;
    data_next = o_rx_data;
    sof_next = o_rx_sof_n;
    eof_next = o_rx_eof_n;
    rem_next = o_rx_rem_n;
    srdy_next = o_rx_src_rdy_n;
    carry_next = carry_reg;
    shift_next = shift_reg;
    pend_next = pend_reg;
    pend_rem0_next = pend_rem0_reg;
    pend_sof_next = pend_sof_reg;
    if (adv) begin
      srdy_next = `RXS_STROBE_OFF;
      sof_next = `RXS_STROBE_OFF;
      eof_next = `RXS_STROBE_OFF;
      rem_next = `RXS_REM_RST;
      if (pend_reg) begin
        srdy_next = 1'b0;
        eof_next = 1'b0;
        rem_next = {1'b1, pend_rem0_reg};
        sof_next = ~pend_sof_reg;
        data_next = {carry_reg, 64'h0};
        pend_next = 1'b0;
        shift_next = 1'b0;
        if (straddle) begin
          s_take = 1'b1;
          sof_next = 1'b0;
          data_next = {carry_reg, s_data[127:64]};
          carry_next = s_data[63:0];
          shift_next = 1'b1;
          if (s_eof) begin
            pend_next = 1'b1;
            pend_rem0_next = s_rem[0];
            pend_sof_next = 1'b0;
          end
        end
      end else if (shift_reg) begin
        if (s_valid) begin
          s_take = 1'b1;
          srdy_next = 1'b0;
          data_next = {carry_reg, s_data[127:64]};
          carry_next = s_data[63:0];
          if (s_eof) begin
            if (s_rem[1]) begin
              eof_next = 1'b0;
              rem_next = {1'b0, s_rem[0]};
              shift_next = 1'b0;
            end else begin
              pend_next = 1'b1;
              pend_rem0_next = s_rem[0];
              pend_sof_next = 1'b0;
            end
          end
        end
      end else if (s_valid) begin
        s_take = 1'b1;
        if (s_eof & s_rem[1]) begin
          pend_next = 1'b1;
          shift_next = 1'b1;
          carry_next = s_data[127:64];
          pend_rem0_next = s_rem[0];
          pend_sof_next = s_sof;
        end else begin
          srdy_next = 1'b0;
          data_next = s_data;
          sof_next = ~s_sof;
          eof_next = ~s_eof;
          rem_next = s_rem;
        end
      end
    end
  end

  always @* begin
    skid_cnt_next = skid_cnt_reg;
    if (push & ~pop) begin
      skid_cnt_next = skid_cnt_reg + 2'd1;
    end else if (~push & pop) begin
      skid_cnt_next = skid_cnt_reg - 2'd1;
    end
  end

  // ==========================================================
  // state registers
  always @(posedge i_core_clk) begin
    if (pop) begin
      if (skid_cnt_reg == `RXS_SKID_FULL) begin
        skid0_reg <= skid1_reg;
      end else begin
        skid0_reg <= in_word;
      end
    end else if (push && (skid_cnt_reg == 2'd0)) begin
      skid0_reg <= in_word;
    end
    if (push && !pop && (skid_cnt_reg == 2'd1)) begin
      skid1_reg <= in_word;
    end
  end

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      skid_cnt_reg <= 2'd0;
      o_in_ready <= 1'b0;
      busy_reg <= 1'b0;
      sel_buf_reg <= 1'b0;
      div_reg <= 1'b0;
      buf_cnt_reg <= CNT_ZERO;
      np_pkts_reg <= CNT_ZERO;
      wr_ptr_reg <= {NP_AW{1'b0}};
      rd_ptr_reg <= {NP_AW{1'b0}};
      carry_reg <= 64'h0;
      shift_reg <= 1'b0;
      pend_reg <= 1'b0;
      pend_rem0_reg <= 1'b0;
      pend_sof_reg <= 1'b0;
      o_rx_data <= `RXS_DATA_RST;
      o_rx_sof_n <= `RXS_STROBE_OFF;
      o_rx_eof_n <= `RXS_STROBE_OFF;
      o_rx_rem_n <= `RXS_REM_RST;
      o_rx_src_rdy_n <= `RXS_STROBE_OFF;
    end else begin
      skid_cnt_reg <= skid_cnt_next;
      o_in_ready <= (skid_cnt_next != `RXS_SKID_FULL);
      if (s_take) begin
        busy_reg <= ~s_eof;
        sel_buf_reg <= use_buf;
      end
      if (pop) begin
        div_reg <= in_div & ~h_eof;
      end
      if (buf_wr) begin
        wr_ptr_reg <= wr_ptr_reg + {{(NP_AW-1){1'b0}}, 1'b1};
      end
      rd_ptr_reg <= buf_raddr;
      if (buf_wr & ~buf_rd) begin
        buf_cnt_reg <= buf_cnt_reg + CNT_ONE;
      end else if (~buf_wr & buf_rd) begin
        buf_cnt_reg <= buf_cnt_reg - CNT_ONE;
      end
      if ((buf_wr & h_eof) & ~(buf_rd & s_eof)) begin
        np_pkts_reg <= np_pkts_reg + CNT_ONE;
      end else if (~(buf_wr & h_eof) & (buf_rd & s_eof)) begin
        np_pkts_reg <= np_pkts_reg - CNT_ONE;
      end
      carry_reg <= carry_next;
      shift_reg <= shift_next;
      pend_reg <= pend_next;
      pend_rem0_reg <= pend_rem0_next;
      pend_sof_reg <= pend_sof_next;
      o_rx_data <= data_next;
      o_rx_sof_n <= sof_next;
      o_rx_eof_n <= eof_next;
      o_rx_rem_n <= rem_next;
      o_rx_src_rdy_n <= srdy_next;
    end
  end

endmodule

// >>> design/rx_tlp_stream_defs.vh
`ifndef RX_TLP_STREAM_DEFS_VH
`define RX_TLP_STREAM_DEFS_VH

// ==========================================================
// beat layout
`define RXS_DATA_W 128
`define RXS_QW_W 64
`define RXS_POS_REM 128
`define RXS_POS_EOF 130
`define RXS_POS_SOF 131
`define RXS_POS_NP 132
`define RXS_BUF_W 132
`define RXS_SKID_W 133

// ==========================================================
// reset values and limits
`define RXS_STROBE_OFF 1'b1
`define RXS_REM_RST 2'b00
`define RXS_DATA_RST 128'h0
`define RXS_SKID_FULL 2'd2

`endif

// >>> verification/rx_tlp_stream_props.sv
`timescale 1ns/1ps
// ====
// user stream framing checks
module rx_tlp_stream_props (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire [127:0] o_rx_data,
  input wire o_rx_sof_n,
  input wire o_rx_eof_n,
  input wire [1:0] o_rx_rem_n,
  input wire o_rx_src_rdy_n,
  input wire i_rx_dst_rdy_n
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  wire vld = !o_rx_src_rdy_n;
  wire xfer = vld && !i_rx_dst_rdy_n;
  reg in_pkt_reg;
  // open packet tracker, so a straddle start is told apart from a plain start
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) in_pkt_reg <= 1'b0;
    else if (xfer) in_pkt_reg <= o_rx_eof_n ? (in_pkt_reg || !o_rx_sof_n) : (in_pkt_reg && !o_rx_sof_n);
  end
  property p_rst_idle; $rose(i_rst_n) |-> o_rx_src_rdy_n && o_rx_sof_n && o_rx_eof_n; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs busy after reset");
  property p_hold; vld && i_rx_dst_rdy_n |=> vld && $stable({o_rx_data, o_rx_sof_n, o_rx_eof_n, o_rx_rem_n}); endproperty
  a_hold: assert property (p_hold) else $error("offered beat changed");
  property p_stall; (vld && i_rx_dst_rdy_n) [*2] |=> $stable(o_rx_data); endproperty
  a_stall: assert property (p_stall) else $error("stream moved in stall");
  property p_first; vld && !in_pkt_reg |-> !o_rx_sof_n; endproperty
  a_first: assert property (p_first) else $error("packet without start");
  property p_strad; vld && in_pkt_reg && !o_rx_sof_n |-> !o_rx_eof_n; endproperty
  a_strad: assert property (p_strad) else $error("start inside open packet");
  property p_strad_rem; vld && in_pkt_reg && !o_rx_sof_n && !o_rx_eof_n |-> o_rx_rem_n[1]; endproperty
  a_strad_rem: assert property (p_strad_rem) else $error("straddle not in upper half");
  property p_single; vld && !in_pkt_reg && !o_rx_sof_n && !o_rx_eof_n |-> !o_rx_rem_n[1]; endproperty
  a_single: assert property (p_single) else $error("bad single beat remainder");
  property p_drop; $rose(o_rx_src_rdy_n) |-> $past(i_rx_dst_rdy_n) == 1'b0; endproperty
  a_drop: assert property (p_drop) else $error("valid withdrawn untaken");
  c_b2b: cover property (xfer && !o_rx_eof_n ##1 vld && !o_rx_sof_n);
  c_stall: cover property (vld && i_rx_dst_rdy_n ##1 xfer);
  c_mid: cover property (xfer && o_rx_sof_n && o_rx_eof_n);
  c_strad: cover property (xfer && !o_rx_sof_n && !o_rx_eof_n && o_rx_rem_n[1]);
endmodule

// >>> verification/rx_tlp_stream_tb.sv
`timescale 1ns/1ps
// ====
// upstream driver, scoreboard and verdict
module rx_tlp_stream_tb;
  reg i_core_clk = 1'b0;
  reg i_rst_n = 1'b0;
  reg i_in_valid = 1'b0;
  reg [127:0] i_in_data = 128'h0;
  reg i_in_sof = 1'b0;
  reg i_in_eof = 1'b0;
  reg [1:0] i_in_rem = 2'h0;
  reg i_in_np = 1'b0;
  reg slow = 1'b0;
  reg hold = 1'b0;
  wire o_in_ready, o_rx_sof_n, o_rx_eof_n, o_rx_src_rdy_n, i_rx_dst_rdy_n, i_rx_np_ok_n;
  wire [127:0] o_rx_data;
  wire [1:0] o_rx_rem_n;
  // notes are quad-words: first, last, upper dword only, data
  logic [66:0] exp_q[$];
  logic [66:0] park_q[$];
  logic [31:0] seed = 32'h9410;
  int err_total = 0;
  int samples_checked = 0;
  initial forever #2 i_core_clk = ~i_core_clk;
  rx_tlp_stream #(.NP_AW(2)) rx_tlp_stream_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_in_valid(i_in_valid), .o_in_ready(o_in_ready), .i_in_data(i_in_data), .i_in_sof(i_in_sof),
    .i_in_eof(i_in_eof), .i_in_rem(i_in_rem), .i_in_np(i_in_np), .o_rx_data(o_rx_data),
    .o_rx_sof_n(o_rx_sof_n), .o_rx_eof_n(o_rx_eof_n), .o_rx_rem_n(o_rx_rem_n),
    .o_rx_src_rdy_n(o_rx_src_rdy_n), .i_rx_dst_rdy_n(i_rx_dst_rdy_n), .i_rx_np_ok_n(i_rx_np_ok_n));
  rx_user_sink rx_user_sink_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_data(o_rx_data),
    .i_sof_n(o_rx_sof_n), .i_rem_n(o_rx_rem_n), .i_src_rdy_n(o_rx_src_rdy_n), .i_slow(slow), .i_hold(hold),
    .o_dst_rdy_n(i_rx_dst_rdy_n), .o_np_ok_n(i_rx_np_ok_n));
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input [66:0] seen, input [66:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  // one quad-word off the user bus against the oldest note; the dword past the end is don't-care
  task automatic take_qw(input is_first, input is_last, input is_half, input [63:0] d);
    logic [66:0] want;
    logic [63:0] m;
    if (exp_q.size() == 0) begin
      err_total++;
      $display("mismatch at %0t: unexpected quad-word", $time);
    end else begin
      want = exp_q.pop_front();
      m = want[64] ? {32'hffffffff, 32'h0} : {64{1'b1}};
      chk({is_first, is_last, is_half, d & m}, {want[66:64], want[63:0] & m});
    end
  endtask
  task automatic note_qw(input [66:0] q, input bit park);
    if (park) park_q.push_back(q);
    else exp_q.push_back(q);
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send_pkt(input int nb, input [1:0] r, input [7:0] hdr, input bit park);
    int t;
    logic [127:0] d;
    logic e;
    for (int b = 0; b < nb; b++) begin
      seed = lfsr(seed);
      d = {seed, ~seed, seed ^ 32'h5a5a5a5a, seed[15:0], seed[31:16]};
      if (b == 0) d[127:120] = hdr;
      e = (b == nb - 1);
      i_in_data = d;
      i_in_sof = (b == 0);
      i_in_eof = e;
      i_in_rem = e ? r : 2'h0;
      i_in_np = (hdr == 8'h00);
      i_in_valid = 1'b1;
      note_qw({b == 0, e && r[1], e && r[1] && r[0], d[127:64]}, park);
      if (!(e && r[1])) note_qw({1'b0, e, e && r[0], d[63:0]}, park);
      t = 0;
      while (!o_in_ready && t < 500) begin
        @(negedge i_core_clk);
        t++;
      end
      if (t == 500) begin
        err_total++;
        report_and_stop;
      end
      @(negedge i_core_clk);
    end
  endtask
  // valid drops here, never in the step where a following packet raises it again
  task automatic wait_empty;
    int t;
    i_in_valid = 1'b0;
    t = 0;
    while (exp_q.size() > 0 && t < 400) begin
      @(negedge i_core_clk);
      t++;
    end
    if (t == 400) begin
      err_total++;
      report_and_stop;
    end
  endtask
  // sof with remainder bit 1 opens a packet in the lower half
  wire low_start = !o_rx_sof_n && o_rx_rem_n[1];
  wire end_high = !o_rx_eof_n && o_rx_rem_n[1];
  wire end_low = !o_rx_eof_n && !o_rx_rem_n[1];
  // sampled at the falling edge, where the beat taken at the next rising edge has settled
  always @(negedge i_core_clk) begin
    if (i_rst_n && !o_rx_src_rdy_n && !i_rx_dst_rdy_n) begin
      if (!low_start || !o_rx_eof_n) begin
        take_qw(!o_rx_sof_n && !low_start, end_high, end_high && o_rx_rem_n[0], o_rx_data[127:64]);
      end
      if (low_start || !end_high) begin
        take_qw(low_start, end_low, end_low && o_rx_rem_n[0], o_rx_data[63:0]);
      end
    end
  end
  initial begin
    repeat (8) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_core_clk);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      slow = (i >= 12);
      // multi-beat packets may end high so the next one straddles; single beats stay at three or four dwords
      send_pkt(1 + seed[3:2] % 3, {seed[1] & (seed[3] ^ seed[2]), seed[0]}, 8'h40, 1'b0);
    end
    // packets ending high are isolated so no straddle is formed
    for (int r = 2; r < 4; r++) begin
      wait_empty;
      send_pkt(2, r, 8'h40, 1'b0);
    end
    wait_empty;
    hold = 1'b1;
    send_pkt(1, 2'h0, 8'h00, 1'b1);
    send_pkt(2, 2'h1, 8'h40, 1'b0);
    wait_empty;
    repeat (6) @(negedge i_core_clk);
    while (park_q.size() > 0) exp_q.push_back(park_q.pop_front());
    hold = 1'b0;
    wait_empty;
    report_and_stop;
  end
endmodule
bind rx_tlp_stream rx_tlp_stream_props rx_tlp_stream_props_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .o_rx_data(o_rx_data), .o_rx_sof_n(o_rx_sof_n), .o_rx_eof_n(o_rx_eof_n), .o_rx_rem_n(o_rx_rem_n),
  .o_rx_src_rdy_n(o_rx_src_rdy_n), .i_rx_dst_rdy_n(i_rx_dst_rdy_n));

// >>> verification/rx_user_sink.sv
`timescale 1ns/1ps
// ====
// user side: throttles and runs the np slot policy
module rx_user_sink (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire [127:0] i_data,
  input wire i_sof_n,
  input wire [1:0] i_rem_n,
  input wire i_src_rdy_n,
  input wire i_slow,
  input wire i_hold,
  output wire o_dst_rdy_n,
  output wire o_np_ok_n
);
  reg [2:0] cnt_reg;
  reg [1:0] free_reg;
  reg np_off_reg;
  wire take = !i_src_rdy_n && !o_dst_rdy_n;
  // a start in the lower half carries its header there
  wire [7:0] fmt_type = i_rem_n[1] ? i_data[63:56] : i_data[127:120];
  wire np_sof = take && !i_sof_n && fmt_type == 8'h00;
  wire drain = cnt_reg == 3'h7 && free_reg != 2'h3;
  // slow mode takes one beat in four, giving long stalls
  assign o_dst_rdy_n = i_slow && cnt_reg[1:0] != 2'h0;
  assign o_np_ok_n = np_off_reg || i_hold;
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 3'h0;
      free_reg <= 2'h3;
      np_off_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      free_reg <= free_reg - {1'b0, np_sof && free_reg != 2'h0} + {1'b0, drain};
      if (free_reg == 2'h3) np_off_reg <= 1'b0;
      else if (np_sof) np_off_reg <= 1'b1;
    end
  end
endmodule
